// File: hw/root_band_pkg.sv
// Package for the signed root and dead-band arithmetic unit.
// Assumes a single clock domain; shared by the unit and its root core.
package root_band_pkg;
  localparam int WORD_W = 16;
  localparam int DBL_W  = 32;
  localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
  localparam logic signed [15:0] SAT_MIN = 16'sh8000;
  // Largest root magnitude that still fits a negative result
  localparam logic [15:0] NEG_MAG_LIMIT  = 16'h8000;
  // Count value of the last of the sixteen root steps
  localparam logic [4:0]  ROOT_LAST_STEP = 5'h0f;
  localparam logic [7:0] ROOT_FUNCTION_CODE = 8'ha7;
  localparam logic [7:0] BAND_FUNCTION_CODE = 8'ha6;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } dbl_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } root_state_t;
endpackage

// File: hw/root_core.sv
// Iterative integer square root of a 32-bit magnitude, one bit per cycle.
// Assumes the start pulse comes from logic on the same clock.
`timescale 1ns/10ps
module root_core (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Request
  input  wire logic        i_start,
  input  wire logic [31:0] i_mag,
  // Answer
  output logic             o_done,
  output logic [15:0]      o_root
);
  import root_band_pkg::*;

  typedef struct packed {
    root_state_t st;
    logic [31:0] rem;
    logic [31:0] num;
    logic [15:0] root;
    logic [4:0]  cnt;
    logic [31:0] mag;
  } core_st_t;

  core_st_t cur_ff;
  core_st_t nxt_st;
  logic [33:0] trial;
  logic [33:0] rem_sh;

  always_comb begin
    nxt_st = cur_ff;
    rem_sh = {cur_ff.rem, cur_ff.num[31:30]};
    trial  = {16'h0000, cur_ff.root, 2'b01};
    case (cur_ff.st)
      ST_IDLE: begin
        if (i_start) begin
          nxt_st.st   = ST_BUSY;
          nxt_st.rem  = 32'h0000_0000;
          nxt_st.num  = i_mag;
          nxt_st.root = 16'h0000;
          nxt_st.cnt  = 5'h00;
          nxt_st.mag  = i_mag;
        end
      end
      ST_BUSY: begin
        // Digit-by-digit root keeps only the integer part
        nxt_st.num = {cur_ff.num[29:0], 2'b00};
        if (rem_sh >= trial) begin //RULE_09
          nxt_st.rem  = 32'(rem_sh - trial);
          nxt_st.root = {cur_ff.root[14:0], 1'b1};
        end else begin
          nxt_st.rem  = rem_sh[31:0];
          nxt_st.root = {cur_ff.root[14:0], 1'b0};
        end
        nxt_st.cnt = cur_ff.cnt + 5'h01;
        if (cur_ff.cnt == ROOT_LAST_STEP) begin
          nxt_st.st = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_st.st = ST_IDLE;
      end
      default: begin
        nxt_st.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_ff <= '{st: ST_IDLE, default: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign o_done = (cur_ff.st == ST_DONE);
  assign o_root = cur_ff.root;

  // Root squared must not pass the latched magnitude, next root must
  a_root_exact: assert property ( //RULE_09
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_done |-> ({16'h0000, o_root} * {16'h0000, o_root} <= cur_ff.mag) &&
    ((34'(o_root) + 34'h1) * (34'(o_root) + 34'h1) > 34'(cur_ff.mag)))
    else $error("root not integer part");
  a_root_latency: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cur_ff.st == ST_IDLE && i_start) |-> ##17 o_done)
    else $error("root latency wrong");
endmodule

// File: hw/signed_sqrt_dead_band_unit.sv
// Signed square-root and dead-band arithmetic unit for a ladder controller.
// Assumes operands and enables come from logic on the same clock.
// Behaviour
// (RULE_01) Root takes |operand|, roots it, restores the sign, stores it.
// (RULE_02) A result above 32767 is overflow, below -32768 underflow.
// (RULE_03) On overflow/underflow the limit is stored and the flag is high; the code holds the flag low while root enable is low.
// (RULE_04) The program supplies a signed 32-bit root operand.
// (RULE_05) With band enable low, no change and the decision stays low.
// (RULE_06) If |value| exceeds |band|, store value shrunk by |band|, flag low.
// (RULE_07) If |value| is within |band|, store zero and raise the decision.
// (RULE_08) The program supplies signed 16-bit value and band operands.
// (RULE_09) The root magnitude is the truncated integer part.
`timescale 1ns/10ps
module signed_sqrt_dead_band_unit (
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  // Square-root operation
  input  wire logic                     i_root_en,
  input  wire root_band_pkg::dbl_word_t i_root_opnd,
  output logic                          o_root_valid,
  output logic [15:0]                   o_root_result,
  output logic                          o_root_ovf,
  // Dead-band operation
  input  wire logic                     i_band_en,
  input  wire logic [15:0]              i_band_value,
  input  wire logic [15:0]              i_band_width,
  output logic [15:0]                   o_band_result,
  output logic                          o_band_in_band
);
  import root_band_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        neg;
    logic        valid;
    logic [15:0] root_res;
    logic        ovf;
    logic [15:0] band_res;
    logic        in_band;
  } unit_st_t;

  unit_st_t           cur_ff;
  unit_st_t           nxt_st;
  logic               core_done;
  logic [15:0]        core_root;
  logic               start;
  logic [31:0]        mag;
  logic signed [31:0] opnd;
  logic signed [16:0] val_x;
  logic signed [16:0] wid_x;
  logic [16:0]        val_abs;
  logic [16:0]        wid_abs;
  logic signed [17:0] shrunk;

  assign opnd  = signed'({i_root_opnd.upper, i_root_opnd.lower}); //RULE_04
  assign mag   = opnd[31] ? 32'(-opnd) : opnd; //RULE_01
  assign start = i_root_en && !cur_ff.busy;

  root_core u_root_core (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (start),
    .i_mag     (mag),
    .o_done    (core_done),
    .o_root    (core_root)
  );

  always_comb begin
    nxt_st       = cur_ff;
    nxt_st.valid = 1'b0;
    val_x   = 17'(signed'(i_band_value)); //RULE_08
    wid_x   = 17'(signed'(i_band_width));
    val_abs = val_x[16] ? 17'(-val_x) : val_x;
    wid_abs = wid_x[16] ? 17'(-wid_x) : wid_x;
    shrunk  = val_x[16] ? 18'(val_x + signed'({1'b0, wid_abs}))
                        : 18'(val_x - signed'({1'b0, wid_abs}));
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.neg  = opnd[31];
    end
    if (!i_root_en) begin
      nxt_st.ovf = 1'b0; //RULE_03
    end
    if (core_done) begin
      nxt_st.busy  = 1'b0;
      nxt_st.valid = 1'b1;
      // Roots reach 46340, past the signed range; clamp to the limits
      if (!cur_ff.neg && core_root[15]) begin //RULE_02
        nxt_st.root_res = SAT_MAX; //RULE_03
        nxt_st.ovf      = 1'b1;
      end else if (cur_ff.neg && core_root > NEG_MAG_LIMIT) begin //RULE_02
        nxt_st.root_res = SAT_MIN; //RULE_03
        nxt_st.ovf      = 1'b1;
      end else begin
        nxt_st.root_res = cur_ff.neg ? 16'(-core_root) : core_root; //RULE_01
        nxt_st.ovf      = 1'b0;
      end
      if (!i_root_en) begin
        nxt_st.ovf = 1'b0;
      end
    end
    if (!i_band_en) begin
      nxt_st.in_band = 1'b0; //RULE_05
    end else if (val_abs > wid_abs) begin
      nxt_st.band_res = shrunk[15:0]; //RULE_06
      nxt_st.in_band  = 1'b0;
    end else begin
      nxt_st.band_res = 16'h0000; //RULE_07
      nxt_st.in_band  = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign o_root_valid   = cur_ff.valid;
  assign o_root_result  = cur_ff.root_res;
  assign o_root_ovf     = cur_ff.ovf;
  assign o_band_result  = cur_ff.band_res;
  assign o_band_in_band = cur_ff.in_band;

  // Dead-band checks
  a_band_off_low: assert property ( //RULE_05
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_band_en |=> !o_band_in_band && $stable(o_band_result))
    else $error("band disabled but output changed");
  a_band_zero: assert property ( //RULE_07
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_band_en && val_abs <= wid_abs) |=> o_band_in_band &&
    o_band_result == 16'h0000) else $error("in-band not zero");
  a_band_shrink: assert property ( //RULE_06
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_band_en && val_abs > wid_abs) |=> !o_band_in_band &&
    o_band_result == $past(shrunk[15:0])) else $error("band shrink bad");
  a_band_flag_en: assert property ( //RULE_05
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_band_in_band |-> $past(i_band_en))
    else $error("decision high without enable");

  // Root checks
  a_root_off_low: assert property ( //RULE_03
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_root_en |=> !o_root_ovf) else $error("ovf high while disabled");
  a_ovf_limit: assert property ( //RULE_03
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_root_valid && o_root_ovf) |-> (o_root_result == SAT_MAX ||
    o_root_result == SAT_MIN)) else $error("ovf without limit");
  a_root_sign: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_root_valid && !o_root_ovf && o_root_result != 16'h0000) |->
    o_root_result[15] == cur_ff.neg) else $error("root sign wrong");
  a_root_pos_ovf: assert property ( //RULE_02
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (core_done && !cur_ff.neg && core_root[15] && i_root_en) |=>
    o_root_ovf && o_root_result == SAT_MAX) else $error("no overflow");
  a_root_neg_udf: assert property ( //RULE_02
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (core_done && cur_ff.neg && core_root > NEG_MAG_LIMIT && i_root_en)
    |=> o_root_ovf && o_root_result == SAT_MIN)
    else $error("no underflow");
  a_root_pos_ok: assert property ( //RULE_03
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (core_done && !cur_ff.neg && !core_root[15]) |=>
    !o_root_ovf && o_root_result == $past(core_root))
    else $error("positive root not stored");
  a_root_neg_ok: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (core_done && cur_ff.neg && core_root <= NEG_MAG_LIMIT) |=>
    !o_root_ovf && o_root_result == 16'(-$past(core_root)))
    else $error("negative root not stored");
  a_valid_pulse: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_root_valid |=> !o_root_valid) else $error("valid longer than a cycle");
  // A request while busy must not disturb the latched sign
  a_busy_hold: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cur_ff.busy && !core_done) |=> $stable(cur_ff.neg))
    else $error("sign changed while busy");
  a_root_done_time: assert property ( //RULE_01
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    start |-> ##18 o_root_valid) else $error("root result late");
endmodule

// File: testbench/tb_signed_sqrt_dead_band_unit.sv
// Self-checking bench for the signed root and dead-band unit.
// Assumes an 18-cycle root answer and a one-cycle band answer.
`timescale 1ns/10ps
module tb_signed_sqrt_dead_band_unit;
  import root_band_pkg::*;
  // Valid rises this many edges after the edge that drives the request
  localparam int ROOT_LAT = 18;
  logic        i_ref_clk, i_rst_n, i_root_en, i_band_en;
  dbl_word_t   i_root_opnd;
  logic [15:0] i_band_value, i_band_width, o_root_result, o_band_result;
  logic        o_root_valid, o_root_ovf, o_band_in_band;
  logic [15:0] last_band;
  logic [31:0] seed;
  int          error_cnt, checked;
  logic [31:0] rc [9] = '{32'h0, 32'h1, 32'hffffffff, 32'h7fffffff,
    32'h80000000, 32'h40000000, 32'h3fff0001, 32'hc0000000, 32'hc2744190};

  signed_sqrt_dead_band_unit dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_root_en(i_root_en), .i_root_opnd(i_root_opnd),
    .o_root_valid(o_root_valid), .o_root_result(o_root_result),
    .o_root_ovf(o_root_ovf), .i_band_en(i_band_en),
    .i_band_value(i_band_value), .i_band_width(i_band_width),
    .o_band_result(o_band_result), .o_band_in_band(o_band_in_band));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0, got}, {15'h0, exp});
  endtask

  // Expected {decision, result} of one dead-band step
  function automatic logic [16:0] band_exp(input logic en,
    input logic [15:0] v, input logic [15:0] w, input logic [15:0] last);
    int a, b, r;
    a = $signed(v);
    b = $signed(w);
    b = b < 0 ? -b : b;
    if (!en) return {1'b0, last};
    if ((a < 0 ? -a : a) <= b) return {1'b1, 16'h0000};
    r = a > 0 ? a - b : a + b;
    return {1'b0, r[15:0]};
  endfunction

  // Expected {flag, result} of one signed root
  function automatic logic [16:0] root_exp(input logic [31:0] op);
    longint m, r, s;
    m = longint'($signed(op));
    m = m < 0 ? -m : m;
    r = 0;
    for (int b = 15; b >= 0; b--) begin
      s = r + (64'sd1 << b);
      if (s * s <= m) r = s;
    end
    s = op[31] ? -r : r;
    if (s > 32767) return {1'b1, SAT_MAX};
    if (s < -32768) return {1'b1, SAT_MIN};
    return {1'b0, s[15:0]};
  endfunction

  task automatic band(input logic en, input logic [15:0] v,
                      input logic [15:0] w);
    logic [16:0] ex;
    ex = band_exp(en, v, w, last_band);
    @(posedge i_ref_clk);
    i_band_en <= en;
    i_band_value <= v;
    i_band_width <= w;
    @(posedge i_ref_clk);
    #1;
    cmp16(o_band_result, ex[15:0]);
    cmp1(o_band_in_band, ex[16]);
    last_band = ex[15:0];
  endtask

  task automatic wait_valid(output int n);
    n = 0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_root_valid === 1'b1) begin
        n = i;
        return;
      end
    end
    error_cnt++;
    summarize();
  endtask

  task automatic root(input logic [31:0] op);
    logic [16:0] ex;
    int          n;
    ex = root_exp(op);
    @(posedge i_ref_clk);
    i_root_en <= 1'b1;
    i_root_opnd <= op;
    wait_valid(n);
    cmp16(16'(n), 16'(ROOT_LAT));
    cmp16(o_root_result, ex[15:0]);
    cmp1(o_root_ovf, ex[16]);
    // Enable still high here, so one more root starts on this edge
    @(posedge i_ref_clk);
    i_root_en <= 1'b0;
    #1;
    cmp1(o_root_valid, 1'b0);
    @(posedge i_ref_clk);
    #1;
    cmp1(o_root_ovf, 1'b0);
    wait_valid(n);
    cmp16(o_root_result, ex[15:0]);
    cmp1(o_root_ovf, 1'b0);
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_root_en = 1'b0;
    i_band_en = 1'b0;
    i_root_opnd = 32'h0;
    i_band_value = 16'h0;
    i_band_width = 16'h0;
    last_band = 16'h0;
    seed = 32'h86aeb393;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    cmp1(o_root_valid, 1'b0);
    cmp1(o_root_ovf, 1'b0);
    cmp16(o_band_result, 16'h0000);
    cmp1(o_band_in_band, 1'b0);
    band(1'b1, 16'h05dc, 16'h03e8);
    band(1'b1, 16'hfa24, 16'h03e8);
    band(1'b1, 16'h03e8, 16'hfc18);
    band(1'b1, 16'h8000, 16'h8000);
    band(1'b1, 16'h8000, 16'h7fff);
    band(1'b0, 16'h1234, 16'h0001);
    band(1'b1, 16'h7fff, 16'h8000);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      band(seed[0], seed[31:16], {{4{seed[15]}}, seed[15:4]});
    end
    foreach (rc[i]) root(rc[i]);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      root(seed);
    end
    summarize();
  end
endmodule
